// file: sram_pipe_consts.svh
// Summary of operation
// - write select low at a qualified edge starts a write; high means read
// - advance high on a qualified edge steps the internal burst counter
// - advance low loads a fresh external address for a new access
// - edges count only while the clock gate is low; otherwise all inputs except sleep, reset and the asynchronous output enable are ignored
// - raising the clock gate stretches the cycle and holds the pipeline; the sleep level is still registered and buffered writes still drain
// - selected only when first and third selects low and second high
// - output enable low lets pins drive read data; high tristates them
// - outputs stay off during write data, first clock after deselect, deselected
// - input data and parity pins are captured on the rising edge
// - driven data is the word addressed at the edge that began the read
// - four eight-bit byte lanes a to d, each with one parity bit
// - parity bits behave like data; written only with their lane's byte select
// - sleep input stops activity while memory contents are kept
// - byte selects are active low and, with write select, enable their lane
// - static burst order input: high interleaved, low linear
// - after a deselecting edge outputs float after the next qualified edge
`ifndef SRAM_PIPE_CONSTS_SVH
`define SRAM_PIPE_CONSTS_SVH
`define LANES        4
`define LANE_W       8
`define WORD_W       36
`define BURST_W      2
`define BURST_STEP   2'h1
`define ADDR_W_DEF   19
`define BUF_DEPTH    2
`define RST_BIT      1'b0
`endif

// file: sram_pipe_pkg.sv
`default_nettype none
`include "sram_pipe_consts.svh"
package sram_pipe_pkg;
  typedef logic [`LANES-1:0]  lane_mask_t;
  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`BURST_W-1:0] burst_t;
endpackage
`default_nettype wire

// file: sram_word_buffer.sv
`timescale 1ns/10ps
`default_nettype none
`include "sram_pipe_consts.svh"
module sram_word_buffer #(
  parameter int W     = 8,
  parameter int DEPTH = `BUF_DEPTH
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW:0]   wr;
    logic [PW:0]   rd;
  } ptr_s;

  ptr_s          s_q;
  ptr_s          s_d;
  logic [W-1:0]  mem [DEPTH];
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;

  // full when pointers differ only in the wrap bit
  assign full      = (s_q.wr[PW] != s_q.rd[PW]) && (s_q.wr[PW-1:0] == s_q.rd[PW-1:0]);
  assign empty     = (s_q.wr == s_q.rd);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[s_q.rd[PW-1:0]];
  assign push      = in_valid & ~full;
  assign pop       = out_ready & ~empty;

  // pointer update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr = (PW+1)'(s_q.wr + 1'b1);
    end
    if (pop) begin
      s_d.rd = (PW+1)'(s_q.rd + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // storage has no reset; only valid entries are read
  always_ff @(posedge clk) begin
    if (push) begin
      mem[s_q.wr[PW-1:0]] <= in_data;
    end
  end
endmodule // sram_word_buffer
`default_nettype wire

// file: sram_pipe_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sram_pipe_consts.svh"
module sram_pipe_top
  import sram_pipe_pkg::*;
#(
  parameter int ADDR_W = `ADDR_W_DEF
) (
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire logic [ADDR_W-1:0] address,
  input  wire logic              write_sel_n,
  input  wire logic              advance_or_load,
  input  wire logic              clock_gate_n,
  input  wire logic              chip_select_first_n,
  input  wire logic              chip_select_second,
  input  wire logic              chip_select_third_n,
  input  wire logic              output_enable_n,
  input  wire logic              byte_write_sel_a_n,
  input  wire logic              byte_write_sel_b_n,
  input  wire logic              byte_write_sel_c_n,
  input  wire logic              byte_write_sel_d_n,
  input  wire logic              burst_order_interleaved,
  input  wire logic              sleep_request,
  input  wire logic [7:0]        data_lane_a_in,
  input  wire logic [7:0]        data_lane_b_in,
  input  wire logic [7:0]        data_lane_c_in,
  input  wire logic [7:0]        data_lane_d_in,
  output logic [7:0]             data_lane_a_out,
  output logic [7:0]             data_lane_b_out,
  output logic [7:0]             data_lane_c_out,
  output logic [7:0]             data_lane_d_out,
  output logic                   data_lane_a_oe,
  output logic                   data_lane_b_oe,
  output logic                   data_lane_c_oe,
  output logic                   data_lane_d_oe,
  input  wire logic              parity_lane_a_in,
  input  wire logic              parity_lane_b_in,
  input  wire logic              parity_lane_c_in,
  input  wire logic              parity_lane_d_in,
  output logic                   parity_lane_a_out,
  output logic                   parity_lane_b_out,
  output logic                   parity_lane_c_out,
  output logic                   parity_lane_d_out,
  output logic                   parity_lane_a_oe,
  output logic                   parity_lane_b_oe,
  output logic                   parity_lane_c_oe,
  output logic                   parity_lane_d_oe,
  output logic                   write_stall
);
  localparam int LW   = `LANE_W;
  localparam int WW   = `WORD_W;
  localparam int BUFW = ADDR_W + `LANES + WW;

  // whole pipeline state in one register
  typedef struct packed {
    logic [ADDR_W-1:0] base;       // address loaded at burst start
    burst_t            cnt;        // burst position
    logic              burst_act;  // a burst may continue
    logic              burst_we;   // direction of that burst
    logic              a_vld;      // stage a: access registered
    logic              a_we;
    logic [ADDR_W-1:0] a_addr;
    lane_mask_t        a_bw;
    logic              b_vld;      // stage b: data phase
    logic              b_we;
    logic [ADDR_W-1:0] b_addr;
    lane_mask_t        b_bw;
    word_t             rd;         // output register
    logic              drive;      // output register holds read data
    logic              sleep;      // registered sleep level
  } pipe_s;

  pipe_s              s_q;
  pipe_s              s_d;
  word_t              mem [2**ADDR_W];
  word_t              pin_word;
  lane_mask_t         bw_now;
  logic               qual;
  logic               sel_now;
  logic               buf_in_ready;
  logic               buf_out_valid;
  logic [BUFW-1:0]    buf_out_data;
  logic               push;
  logic [ADDR_W-1:0]  wr_addr;
  lane_mask_t         wr_bw;
  word_t              wr_word;
  logic               lane_drive;
  logic [WW-1:0]      wr_mask;

  // pins packed into one word: each lane is parity then eight data bits
  assign pin_word = {parity_lane_d_in, data_lane_d_in, parity_lane_c_in, data_lane_c_in,
                     parity_lane_b_in, data_lane_b_in, parity_lane_a_in, data_lane_a_in};
  assign bw_now   = ~{byte_write_sel_d_n, byte_write_sel_c_n,
                      byte_write_sel_b_n, byte_write_sel_a_n};

  // gate qualifies the edge
  // a full write buffer stalls the edge too, so no write word is dropped
  assign qual        = ~clock_gate_n & buf_in_ready;
  assign write_stall = ~buf_in_ready;
  assign sel_now = ~chip_select_first_n & chip_select_second & ~chip_select_third_n;

  // burst order: interleaved xors the count in, linear adds it
  function automatic burst_t burst_low(input burst_t start, input burst_t pos,
                                       input logic interleaved);
    burst_low = interleaved ? (start ^ pos) : burst_t'(start + pos);
  endfunction

  // next pipeline state
  always_comb begin
    s_d        = s_q;
    s_d.sleep  = sleep_request;
    push       = 1'b0;
    if (qual) begin
      // stage a moves to the data phase
      s_d.b_vld = s_q.a_vld;
      s_d.b_we  = s_q.a_we;
      s_d.b_addr = s_q.a_addr;
      s_d.b_bw  = s_q.a_bw;
      s_d.a_vld = 1'b0;
      if (s_q.sleep) begin
        s_d.burst_act = 1'b0;
      end else if (!advance_or_load) begin
        s_d.burst_act = sel_now;
        s_d.a_vld     = sel_now;
        s_d.burst_we  = ~write_sel_n;
        s_d.a_we      = ~write_sel_n;
        s_d.base      = address;
        s_d.cnt       = '0;
        s_d.a_addr    = address;
        s_d.a_bw      = bw_now;
      end else if (s_q.burst_act) begin
        // two bits wrap after four words
        s_d.cnt    = burst_t'(s_q.cnt + `BURST_STEP);
        s_d.a_vld  = 1'b1;
        s_d.a_we   = s_q.burst_we;
        s_d.a_bw   = bw_now;
        s_d.a_addr = {s_q.base[ADDR_W-1:`BURST_W],
                      burst_low(s_q.base[`BURST_W-1:0], s_d.cnt, burst_order_interleaved)};
      end
      // word of the edge that began the read
      s_d.rd    = mem[s_q.a_addr];
      // off for writes, idle and deselect
      // float after the next qualified edge
      s_d.drive = s_q.a_vld & ~s_q.a_we;
      // capture pins at the end of a write data phase
      push      = s_q.b_vld & s_q.b_we;
    end
    if (s_q.sleep) begin
      s_d.drive = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // write words wait here while the core sleeps
  sram_word_buffer #(
    .W     (BUFW),
    .DEPTH (`BUF_DEPTH)
  ) u_wbuf (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (push),
    .in_ready  (buf_in_ready),
    .in_data   ({s_q.b_addr, s_q.b_bw, pin_word}),
    .out_valid (buf_out_valid),
    .out_ready (~s_q.sleep),
    .out_data  (buf_out_data)
  );

  assign wr_addr = buf_out_data[BUFW-1 -: ADDR_W];
  assign wr_bw   = buf_out_data[WW +: `LANES];
  assign wr_word = buf_out_data[WW-1:0];

  // four lanes of data plus parity
  // parity written with its lane only
  genvar g;
  generate
    for (g = 0; g < `LANES; g++) begin : g_lane
      assign wr_mask[g*(LW+1) +: LW+1] = {(LW+1){wr_bw[g]}};
    end
  endgenerate

  // one write port: the lane mask keeps unselected lanes untouched
  always_ff @(posedge clk) begin
    if (buf_out_valid && !s_q.sleep) begin
      mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_word & wr_mask);
    end
  end

  // async enable masks the registered drive
  assign lane_drive = s_q.drive & ~output_enable_n;
  assign data_lane_a_oe   = lane_drive;
  assign data_lane_b_oe   = lane_drive;
  assign data_lane_c_oe   = lane_drive;
  assign data_lane_d_oe   = lane_drive;
  assign parity_lane_a_oe = lane_drive;
  assign parity_lane_b_oe = lane_drive;
  assign parity_lane_c_oe = lane_drive;
  assign parity_lane_d_oe = lane_drive;

  // output register split back into lanes
  assign data_lane_a_out   = s_q.rd[0*(LW+1) +: LW];
  assign parity_lane_a_out = s_q.rd[0*(LW+1) + LW];
  assign data_lane_b_out   = s_q.rd[1*(LW+1) +: LW];
  assign parity_lane_b_out = s_q.rd[1*(LW+1) + LW];
  assign data_lane_c_out   = s_q.rd[2*(LW+1) +: LW];
  assign parity_lane_c_out = s_q.rd[2*(LW+1) + LW];
  assign data_lane_d_out   = s_q.rd[3*(LW+1) +: LW];
  assign parity_lane_d_out = s_q.rd[3*(LW+1) + LW];
endmodule // sram_pipe_top
`default_nettype wire

// file: sram_pipe_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module sram_pipe_asserts (
  input wire logic       clk,
  input wire logic       rst_n,
  input wire logic       write_sel_n,
  input wire logic       advance_or_load,
  input wire logic       clock_gate_n,
  input wire logic       chip_select_first_n,
  input wire logic       chip_select_second,
  input wire logic       chip_select_third_n,
  input wire logic       output_enable_n,
  input wire logic       sleep_request,
  input wire logic       write_stall,
  input wire logic [7:0] data_lane_a_out,
  input wire logic       data_lane_a_oe,
  input wire logic       data_lane_b_oe,
  input wire logic       data_lane_c_oe,
  input wire logic       data_lane_d_oe,
  input wire logic       parity_lane_a_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // qualified edge and full selection
  wire q   = !clock_gate_n && !write_stall;
  wire sel = !chip_select_first_n && chip_select_second && !chip_select_third_n;
  sequence load_s;
    q && !advance_or_load;
  endsequence
  // sleep is looked at twice since it is registered once inside
  sequence read_s;
    load_s ##0 (sel && write_sel_n && !sleep_request && !$past(sleep_request));
  endsequence
  a_gate_holds_out: assert property (!q |=> $stable(data_lane_a_out))
    else $error("output data moved on an ignored edge");
  a_oe_masked: assert property (output_enable_n |-> !data_lane_a_oe && !parity_lane_a_oe)
    else $error("pins driven while output enable high");
  a_lanes_agree: assert property (data_lane_a_oe == data_lane_b_oe &&
    data_lane_c_oe == data_lane_d_oe && data_lane_a_oe == data_lane_c_oe)
    else $error("byte lanes disagree on drive");
  a_parity_follows: assert property (parity_lane_a_oe == data_lane_a_oe)
    else $error("parity drive differs from data drive");
  a_desel_floats: assert property (load_s ##0 !sel ##1 q |=> !data_lane_a_oe)
    else $error("pins still driven after deselect");
  a_write_floats: assert property (load_s ##0 (sel && !write_sel_n) ##1 q |=> !data_lane_a_oe)
    else $error("pins driven in write data phase");
  a_read_drives: assert property (read_s ##1 (q && !sleep_request) |=>
    data_lane_a_oe == !output_enable_n)
    else $error("read data not driven one edge after its address");
  // sleep is registered once, so the drive drops one edge later
  a_sleep_quiets: assert property (sleep_request |=> ##1 !data_lane_a_oe)
    else $error("pins driven while asleep");
endmodule // sram_pipe_asserts
bind sram_pipe_top sram_pipe_asserts chk (
  .clk                 (clk),
  .rst_n               (rst_n),
  .write_sel_n         (write_sel_n),
  .advance_or_load     (advance_or_load),
  .clock_gate_n        (clock_gate_n),
  .chip_select_first_n (chip_select_first_n),
  .chip_select_second  (chip_select_second),
  .chip_select_third_n (chip_select_third_n),
  .output_enable_n     (output_enable_n),
  .sleep_request       (sleep_request),
  .write_stall         (write_stall),
  .data_lane_a_out     (data_lane_a_out),
  .data_lane_a_oe      (data_lane_a_oe),
  .data_lane_b_oe      (data_lane_b_oe),
  .data_lane_c_oe      (data_lane_c_oe),
  .data_lane_d_oe      (data_lane_d_oe),
  .parity_lane_a_oe    (parity_lane_a_oe)
);
`default_nettype wire

// file: sram_master_model.sv
`timescale 1ns/10ps
`default_nettype none
module sram_master_model (
  input  wire logic        clk,
  input  wire logic        drive,
  input  wire logic [35:0] word,
  input  wire logic [35:0] dev_out,
  input  wire logic [7:0]  dev_oe,
  output logic [35:0]      pins
);
  logic [35:0] last_q;
  // wire level
  // an undriven pin shows the inverse of its last level, so stale data never matches
  always_comb begin
    for (int i = 0; i < 36; i++) begin
      pins[i] = dev_oe[(i % 9 == 8) ? 4 + i / 9 : i / 9] ? dev_out[i] :
                drive ? word[i] : ~last_q[i];
    end
  end
  // last level seen on the wire
  always_ff @(posedge clk) begin
    last_q <= pins;
  end
endmodule // sram_master_model
`default_nettype wire

// file: tb_pipelined_sram_pin_control.sv
`timescale 1ns/10ps
`default_nettype none
module tb_pipelined_sram_pin_control;
  logic        clk = 1'b0, rst_n = 1'b0, g = 1'b0, adv = 1'b0, wen = 1'b1;
  logic        oen = 1'b0, md = 1'b0, mode = 1'b0, slp = 1'b0;
  logic [2:0]  cs = 3'h5; // first_n, second, third_n; 3'h2 selects
  logic [3:0]  bw = 4'h0;
  logic [18:0] ad = 19'h0;
  logic [35:0] mw = 36'h0;
  wire  [35:0] pw, dout;
  wire  [7:0]  doe;
  wire         stall;
  int          err_total = 0, comparisons = 0;
  always #25 clk = ~clk;
  sram_pipe_top uut (
    .clk(clk), .rst_n(rst_n), .address(ad), .write_sel_n(wen), .advance_or_load(adv),
    .clock_gate_n(g), .chip_select_first_n(cs[2]), .chip_select_second(cs[1]),
    .chip_select_third_n(cs[0]), .output_enable_n(oen), .byte_write_sel_a_n(bw[0]),
    .byte_write_sel_b_n(bw[1]), .byte_write_sel_c_n(bw[2]), .byte_write_sel_d_n(bw[3]),
    .burst_order_interleaved(mode), .sleep_request(slp), .data_lane_a_in(pw[7:0]),
    .data_lane_b_in(pw[16:9]), .data_lane_c_in(pw[25:18]), .data_lane_d_in(pw[34:27]),
    .parity_lane_a_in(pw[8]), .parity_lane_b_in(pw[17]), .parity_lane_c_in(pw[26]),
    .parity_lane_d_in(pw[35]), .data_lane_a_out(dout[7:0]), .data_lane_b_out(dout[16:9]),
    .data_lane_c_out(dout[25:18]), .data_lane_d_out(dout[34:27]),
    .parity_lane_a_out(dout[8]), .parity_lane_b_out(dout[17]), .parity_lane_c_out(dout[26]),
    .parity_lane_d_out(dout[35]), .data_lane_a_oe(doe[0]), .data_lane_b_oe(doe[1]),
    .data_lane_c_oe(doe[2]), .data_lane_d_oe(doe[3]), .parity_lane_a_oe(doe[4]),
    .parity_lane_b_oe(doe[5]), .parity_lane_c_oe(doe[6]), .parity_lane_d_oe(doe[7]),
    .write_stall(stall));
  sram_master_model partner (.clk(clk), .drive(md), .word(mw), .dev_out(dout),
    .dev_oe(doe), .pins(pw));
  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] s);
    comparisons++;
    if (s !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one cycle: inputs move after the edge and hold to the next; nonzero d is driven
  task automatic cyc(input logic [2:0] c, input logic v, input logic w,
                     input logic [18:0] a, input logic [35:0] d);
    @(posedge clk);
    cs <= c;
    adv <= v;
    wen <= w;
    ad <= a;
    mw <= d;
    md <= |d;
  endtask
  // load a read, then two deselecting loads; look after the edge that loads data
  task automatic rd(input logic [2:0] c, input logic [18:0] a, input logic [35:0] e,
                    input logic eo);
    cyc(c, 1'b0, 1'b1, a, 36'h0);
    cyc(3'h5, 1'b0, 1'b1, a, 36'h0);
    cyc(3'h5, 1'b0, 1'b1, a, 36'h0);
    @(negedge clk);
    chk("drive", {28'h0, {8{eo}}}, {28'h0, doe});
    if (eo) chk("read word", e, pw);
  endtask
  // write data goes on the pins two edges after its load
  task automatic wr(input logic [18:0] a, input logic [35:0] d);
    cyc(3'h2, 1'b0, 1'b0, a, 36'h0);
    cyc(3'h5, 1'b0, 1'b1, a, 36'h0);
    cyc(3'h5, 1'b0, 1'b1, a, d);
    cyc(3'h5, 1'b0, 1'b1, a, 36'h0);
  endtask
  task automatic t_basic();
    wr(19'h00123, 36'h3c5a96e01);
    rd(3'h2, 19'h00123, 36'h3c5a96e01, 1'b1);
    @(posedge clk);
    oen <= 1'b1;
    rd(3'h2, 19'h00123, 36'h0, 1'b0);
    @(posedge clk);
    oen <= 1'b0;
  endtask
  // lanes a and c masked: their data and parity keep the old value
  task automatic t_bytes();
    bw <= 4'h5;
    wr(19'h00123, 36'hc3a5691fe);
    bw <= 4'h0;
    rd(3'h2, 19'h00123, 36'hc3a5691fe & 36'hff803fe00 | 36'h3c5a96e01 & 36'h007fc01ff,
       1'b1);
  endtask
  task automatic t_desel();
    rd(3'h6, 19'h00123, 36'h0, 1'b0);
    rd(3'h0, 19'h00123, 36'h0, 1'b0);
    rd(3'h3, 19'h00123, 36'h0, 1'b0);
  endtask
  // a write loaded while the gate is high must vanish; the read waits
  task automatic t_gate();
    cyc(3'h2, 1'b0, 1'b1, 19'h00123, 36'h0);
    cyc(3'h2, 1'b0, 1'b0, 19'h00123, 36'h0);
    g <= 1'b1;
    cyc(3'h2, 1'b0, 1'b0, 19'h00123, 36'h0);
    cyc(3'h5, 1'b0, 1'b1, 19'h0, 36'h0);
    g <= 1'b0;
    cyc(3'h5, 1'b0, 1'b1, 19'h0, 36'h0);
    @(negedge clk);
    chk("gated read", {28'h0, 8'hff}, {28'h0, doe});
    chk("stretched word", 36'hc3daa9001, pw);
    rd(3'h2, 19'h00123, 36'hc3daa9001, 1'b1);
  endtask
  // linear write burst at base 1, interleaved read back
  task automatic t_burst();
    for (int k = 0; k < 7; k++) cyc(k < 4 ? 3'h2 : 3'h5, k inside {[1:3]}, k >= 4,
      19'h00041, (k >= 2 && k < 6) ? 36'h9a5c3e100 ^ (k - 2) : 36'h0);
    mode <= 1'b1;
    for (int k = 0; k < 6; k++) begin
      cyc(k < 4 ? 3'h2 : 3'h5, k inside {[1:3]}, 1'b1, 19'h00041, 36'h0);
      @(negedge clk);
      if (k >= 2) chk("burst", 36'h9a5c3e100 ^ (((1 ^ (k - 2)) - 1) & 3), pw);
    end
  endtask
  // sleep holds two write words in the buffer, which fills it and stalls, until sleep drops
  task automatic t_sleep();
    int n;
    cyc(3'h2, 1'b0, 1'b0, 19'h00300, 36'h0);
    cyc(3'h2, 1'b0, 1'b0, 19'h00301, 36'h0);
    slp <= 1'b1;
    cyc(3'h5, 1'b0, 1'b1, 19'h0, 36'h0aa55aa55);
    cyc(3'h5, 1'b0, 1'b1, 19'h0, 36'h155aa55aa);
    cyc(3'h5, 1'b0, 1'b1, 19'h0, 36'h0);
    @(negedge clk);
    chk("stall", 36'h1, {35'h0, stall});
    chk("asleep drive", 36'h0, {28'h0, doe});
    @(posedge clk);
    slp <= 1'b0;
    for (n = 0; n < 20 && stall !== 1'b0; n++) @(negedge clk);
    if (stall !== 1'b0) begin
      chk("stall clears", 36'h0, {35'h0, stall});
    end else begin
      rd(3'h2, 19'h00300, 36'h0aa55aa55, 1'b1);
      rd(3'h2, 19'h00301, 36'h155aa55aa, 1'b1);
    end
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk("reset state", 36'h0, {27'h0, stall, doe});
    t_basic();
    t_bytes();
    t_desel();
    t_gate();
    t_burst();
    t_sleep();
    wrap_up();
  end
endmodule // tb_pipelined_sram_pin_control
`default_nettype wire
